// [qvs_line_range.sv]
`timescale 1ns/1ps
module qvs_line_range
  import qvs_pkg::*;
#(
  parameter int unsigned BLANK = LL_BLANK_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic below_low_i,
  input wire logic above_high_i,
  output logic high_line_o
);
  logic high_r, high_nxt;
  logic [31:0] cnt_r, cnt_nxt;

  always_comb begin
    high_nxt = high_r;
    cnt_nxt = 32'h0;
    if (above_high_i) begin
      high_nxt = 1'b1;
    end else if (below_low_i) begin
      cnt_nxt = (cnt_r == 32'(BLANK)) ? cnt_r : cnt_r + 32'h1;
      if (cnt_r == 32'(BLANK)) begin
        high_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_r <= LINE_HIGH_RST;
      cnt_r <= 32'h0;
    end else begin
      high_r <= high_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign high_line_o = high_r;

  high_immediate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    above_high_i |=> high_line_o) else $error("high line late");
  low_blanked_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ($fell(high_line_o)) |-> $past(below_low_i))
    else $error("low line without blank");
endmodule

// [qvs_partner.sv]
`timescale 1ns/1ps
module qvs_partner (
  input wire logic clk_i,
  input wire logic gate_i,
  input wire logic [1:0] mode_i,
  output logic valley_below_o,
  output logic short_release_o,
  output logic cs_above_o
);
  // Mode 0 rings, mode 1 is damped flat, mode 2 has a shorted valley node.
  int cnt = 0;
  logic last_g = 1'b0;
  always @(posedge clk_i) begin
    #2;
    cnt = (gate_i != last_g) ? 0 : cnt + 1;
    last_g = gate_i;
    cs_above_o = gate_i && cnt >= 3;
    short_release_o = !gate_i && cnt < 3 && mode_i != 2'h2;
    valley_below_o = gate_i || mode_i == 2'h2 ||
      (cnt >= 4 && (mode_i == 2'h1 || (cnt - 4) % 8 < 4));
  end
endmodule

// [qvs_pkg.sv]
package qvs_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TIMEOUT_NS = 6500;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_NS * CLK_MHZ / 1000;
  localparam int unsigned LL_BLANK_MS = 25;
  localparam int unsigned LL_BLANK_CYC = LL_BLANK_MS * 1000 * CLK_MHZ;
  localparam int unsigned SHORT_MS = 90;
  localparam int unsigned SHORT_CYC = SHORT_MS * 1000 * CLK_MHZ;
  localparam int unsigned RECOVER_S = 4;
  localparam longint unsigned RECOVER_CYC =
    64'(RECOVER_S) * 64'd1000000000 / 64'd4;
  localparam int unsigned SETPT_DIV_SHIFT = 2;
  localparam int unsigned FILT_SHIFT = 6;
  localparam logic LINE_HIGH_RST = 1'b1;

  typedef enum {
    QVS_OFF,
    QVS_START,
    QVS_RUN,
    QVS_FAULT_WAIT,
    QVS_LATCHED
  } qvs_state_e;

  typedef struct packed {
    logic valley_below;
    logic short_release;
    logic line_below_low;
    logic line_above_high;
    logic cs_above_sp;
  } qvs_cmp_s;

  function automatic logic [7:0] qvs_sat_inc(input logic [7:0] v);
    qvs_sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction
endpackage

// [qvs_sequencer.sv]
`timescale 1ns/1ps
module qvs_sequencer
  import qvs_pkg::*;
#(
  parameter int unsigned SHORT_LIMIT = SHORT_CYC,
  parameter longint unsigned RECOVER_LIMIT = RECOVER_CYC,
  parameter int unsigned BLANK_LIMIT = LL_BLANK_CYC,
  parameter int unsigned TIMEOUT_LIMIT = TIMEOUT_CYC,
  parameter bit AUTO_RECOVER = 1'b1,
  parameter int unsigned LOOP_W = 10
) (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire qvs_cmp_s CMP_I,
  input wire logic SUPPLY_ON_I,
  input wire logic SUPPLY_OFF_I,
  input wire logic FOLDBACK_ACTIVE_I,
  input wire logic BRIGHTNESS_FULL_I,
  input wire logic [2:0] FOLDBACK_SKIP_I,
  input wire logic MAJOR_FAULT_I,
  input wire logic AMP_SINKING_I,
  input wire logic [LOOP_W-1:0] LOOP_LEVEL_I,
  output logic GATE_O,
  output logic ON_LATCH_O,
  output logic [LOOP_W-1:0] SETPOINT_O,
  output logic LOOP_GROUND_O,
  output logic BOOST_SRC_O,
  output logic REF_FULL_O,
  output logic HIGH_LINE_O,
  output logic SHORT_FAULT_O,
  output logic LATCHED_O
);
  qvs_state_e st_r, st_nxt;
  logic gate_r, gate_nxt;
  logic boost_r, boost_nxt;
  logic [2:0] vcnt_r, vcnt_nxt;
  logic [31:0] scnt_r, scnt_nxt;
  logic [63:0] rcnt_r, rcnt_nxt;
  logic short_r, short_nxt;
  logic [LOOP_W+FILT_SHIFT-1:0] acc_r, acc_nxt;
  logic [LOOP_W-1:0] sp_r, sp_nxt;
  logic ref_r, ref_nxt;
  logic valley_evt;
  logic high_line;
  logic fault_any;
  logic [2:0] need;
  logic [LOOP_W-1:0] filt;
  logic [7:0] vinc;
  logic keep_r, keep_nxt;

  qvs_valley_timer #(.TIMEOUT(TIMEOUT_LIMIT)) u_vt (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .below_i(CMP_I.valley_below),
    .valley_evt_o(valley_evt)
  );

  qvs_line_range #(.BLANK(BLANK_LIMIT)) u_lr (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .below_low_i(CMP_I.line_below_low),
    .above_high_i(CMP_I.line_above_high),
    .high_line_o(high_line)
  );

  // Setpoint path: a leaky average removes the loop-node ripple.
  always_comb begin
    filt = acc_r[LOOP_W+FILT_SHIFT-1:FILT_SHIFT];
    acc_nxt = acc_r - (LOOP_W+FILT_SHIFT)'(filt)
      + (LOOP_W+FILT_SHIFT)'(LOOP_LEVEL_I);
    sp_nxt = filt >> SETPT_DIV_SHIFT;
    ref_nxt = !FOLDBACK_ACTIVE_I && BRIGHTNESS_FULL_I;
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      acc_r <= '0;
      sp_r <= '0;
      ref_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      sp_r <= sp_nxt;
      ref_r <= ref_nxt;
    end
  end

  // Short timer restarts when the valley node climbs above 1 V, outside QVS_RUN, and after it fires.
  always_comb begin
    scnt_nxt = scnt_r;
    short_nxt = 1'b0;
    if (st_r != QVS_RUN || CMP_I.short_release) begin
      scnt_nxt = 32'h0;
    end else if (scnt_r == 32'(SHORT_LIMIT - 1)) begin
      scnt_nxt = 32'h0;
      short_nxt = 1'b1;
    end else begin
      scnt_nxt = scnt_r + 32'h1;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      scnt_r <= 32'h0;
      short_r <= 1'b0;
    end else begin
      scnt_r <= scnt_nxt;
      short_r <= short_nxt;
    end
  end

  assign fault_any = short_r || MAJOR_FAULT_I || SUPPLY_OFF_I;

  // Valleys required before the next turn-on.
  always_comb begin
    need = high_line ? 3'd2 : 3'd1;
    if (FOLDBACK_ACTIVE_I) begin
      need = need + FOLDBACK_SKIP_I;
    end
  end

  // Main sequencing: start-up, switching, fault handling.
  always_comb begin
    st_nxt = st_r;
    gate_nxt = gate_r;
    boost_nxt = boost_r;
    vcnt_nxt = vcnt_r;
    rcnt_nxt = 64'h0;
    keep_nxt = keep_r;
    // The count is compared at full width so a wrap cannot hide a valley.
    vinc = qvs_sat_inc({5'h00, vcnt_r});
    case (st_r)
      QVS_OFF: begin
        gate_nxt = 1'b0;
        if (SUPPLY_ON_I && !SUPPLY_OFF_I) begin
          st_nxt = QVS_START;
          keep_nxt = 1'b0;
          boost_nxt = 1'b1;
        end
      end
      QVS_START, QVS_RUN: begin
        if (st_r == QVS_START) begin
          st_nxt = QVS_RUN;
        end
        if (AMP_SINKING_I) begin
          boost_nxt = 1'b0;
        end
        if (gate_r && CMP_I.cs_above_sp) begin
          gate_nxt = 1'b0;
          vcnt_nxt = 3'd0;
        end else if (!gate_r && valley_evt && !fault_any) begin
          if (vinc >= {5'h00, need}) begin
            gate_nxt = 1'b1;
            vcnt_nxt = 3'd0;
          end else begin
            vcnt_nxt = vcnt_r + 3'd1;
          end
        end
        if (fault_any) begin
          gate_nxt = 1'b0;
          boost_nxt = 1'b0;
        end
        if (SUPPLY_OFF_I) begin
          // Remember the undervoltage exit so the retry keeps the loop level.
          st_nxt = QVS_OFF;
          keep_nxt = 1'b1;
        end else if (short_r || MAJOR_FAULT_I) begin
          st_nxt = AUTO_RECOVER ? QVS_FAULT_WAIT : QVS_LATCHED;
        end
      end
      QVS_FAULT_WAIT: begin
        gate_nxt = 1'b0;
        rcnt_nxt = rcnt_r + 64'h1;
        if (rcnt_r == RECOVER_LIMIT - 1) begin
          st_nxt = QVS_OFF;
        end
      end
      QVS_LATCHED: begin
        gate_nxt = 1'b0;
      end
      default: begin
        st_nxt = QVS_OFF;
        gate_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r <= QVS_OFF;
      gate_r <= 1'b0;
      boost_r <= 1'b0;
      vcnt_r <= 3'd0;
      rcnt_r <= 64'h0;
      keep_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      gate_r <= gate_nxt;
      boost_r <= boost_nxt;
      vcnt_r <= vcnt_nxt;
      rcnt_r <= rcnt_nxt;
      keep_r <= keep_nxt;
    end
  end

  assign GATE_O = gate_r;
  assign ON_LATCH_O = gate_r;
  assign SETPOINT_O = sp_r;
  // Undervoltage keeps the loop level so a retry resumes from it.
  // Any other off state holds the loop node at ground.
  assign LOOP_GROUND_O = (st_r == QVS_FAULT_WAIT)
    || (st_r == QVS_LATCHED)
    || (st_r == QVS_OFF && !keep_r);
  assign BOOST_SRC_O = boost_r;
  assign REF_FULL_O = ref_r;
  assign HIGH_LINE_O = high_line;
  assign SHORT_FAULT_O = short_r;
  assign LATCHED_O = (st_r == QVS_LATCHED);

  sequence s_on;
    gate_r && CMP_I.cs_above_sp;
  endsequence
  sequence s_off;
    !gate_r;
  endsequence
  sequence s_uv_in;
    (st_r == QVS_RUN || st_r == QVS_START) && SUPPLY_OFF_I;
  endsequence

  gate_end_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    s_on |=> s_off) else $error("gate not ended by sense");
  ref_full_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    FOLDBACK_ACTIVE_I |=> !REF_FULL_O)
    else $error("reference full in foldback");
  fault_ground_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (st_r == QVS_RUN && MAJOR_FAULT_I && !SUPPLY_OFF_I) |=> LOOP_GROUND_O)
    else $error("loop node not grounded");
  boost_start_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (st_r == QVS_OFF && st_nxt == QVS_START) |=> BOOST_SRC_O)
    else $error("boost not enabled");
  uvlo_keep_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    s_uv_in |=> (st_r == QVS_OFF && !LOOP_GROUND_O))
    else $error("loop level reset on retry");
  short_fire_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (scnt_r == 32'(SHORT_LIMIT - 1) && st_r == QVS_RUN
    && !CMP_I.short_release) |=> SHORT_FAULT_O)
    else $error("short fault missed");
  short_stop_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    SHORT_FAULT_O |=> !GATE_O [*2])
    else $error("switching after short");
  fault_block_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (!gate_r && fault_any) |=> !GATE_O)
    else $error("pulse despite fault");
  on_latch_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    ON_LATCH_O == GATE_O) else $error("on latch mismatch");
  valley_two_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (st_r == QVS_RUN && !gate_r && valley_evt && vcnt_r == 3'd0
    && high_line && !fault_any && !CMP_I.cs_above_sp) |=> !GATE_O)
    else $error("high line on first valley");

  // Start-up, valley, short-timer, reference, recovery and off-state checks.
  boost_hold_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (BOOST_SRC_O && !AMP_SINKING_I && st_r == QVS_RUN && !fault_any)
    |=> BOOST_SRC_O)
    else $error("boost dropped early");
  start_run_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (st_r == QVS_START && !SUPPLY_OFF_I && !short_r && !MAJOR_FAULT_I)
    |=> (st_r == QVS_RUN))
    else $error("start not followed by run");
  valley_one_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (st_r == QVS_RUN && !gate_r && valley_evt && !high_line
    && !FOLDBACK_ACTIVE_I && !fault_any) |=> GATE_O)
    else $error("low line first valley missed");
  short_clear_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    CMP_I.short_release |=> (scnt_r == 32'h0))
    else $error("short timer not restarted");
  recover_wait_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (st_r == QVS_FAULT_WAIT && rcnt_r < RECOVER_LIMIT - 1)
    |=> (st_r == QVS_FAULT_WAIT && !GATE_O))
    else $error("recovery pause cut short");
  off_ground_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (st_r == QVS_FAULT_WAIT && st_nxt == QVS_OFF) |=> LOOP_GROUND_O)
    else $error("loop node released when off");
  ref_dim_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !BRIGHTNESS_FULL_I |=> !REF_FULL_O)
    else $error("reference full while dimmed");
  latch_stay_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    LATCHED_O |=> LATCHED_O) else $error("latch left");
  uv_gate_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    SUPPLY_OFF_I |=> !GATE_O)
    else $error("pulse in undervoltage");
endmodule

// [qvs_valley_timer.sv]
`timescale 1ns/1ps
module qvs_valley_timer
  import qvs_pkg::*;
#(
  parameter int unsigned TIMEOUT = TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic below_i,
  output logic valley_evt_o
);
  logic below_r, below_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic tout;

  always_comb begin
    below_nxt = below_i;
    tout = below_i && (cnt_r == 16'(TIMEOUT - 1));
    if (!below_i || tout) begin
      cnt_nxt = 16'h0000;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    // A falling crossing or a time-out both count as a valley.
    valley_evt_o = (below_i && !below_r) || tout;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      below_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else begin
      below_r <= below_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  tout_period_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cnt_r == 16'(TIMEOUT - 1) && below_i) |-> valley_evt_o ##1
    (cnt_r == 16'h0000)) else $error("time-out not issued");
endmodule

// [tb_qr_valley_fault_sequencer.sv]
`timescale 1ns/1ps
module tb_qr_valley_fault_sequencer
  import qvs_pkg::*;
;
  localparam int SL = 50;
  localparam int RL = 100;
  localparam int BL = 40;
  localparam int TL = 20;
  logic clk = 1'b0, rst_n = 1'b0, sup_on = 1'b0, sup_off = 1'b0;
  logic fold = 1'b0, bright = 1'b1, major = 1'b0, sink = 1'b0;
  logic lo = 1'b0, hi = 1'b0, g_q = 1'b0;
  logic gate2, gnd2, lat2;
  logic [2:0] skip = 3'h0;
  logic [9:0] lvl = 10'h168;
  logic [1:0] mode = 2'h0;
  logic vb, sr, cs, gate, on_l, gnd, boost, rf, hl, sf, lat;
  logic [9:0] sp;
  qvs_cmp_s cmp;
  int bad_count = 0;
  int n_checks = 0;
  assign cmp = {vb, sr, lo, hi, cs};
  qvs_sequencer #(.SHORT_LIMIT(SL), .RECOVER_LIMIT(RL), .BLANK_LIMIT(BL),
    .TIMEOUT_LIMIT(TL), .AUTO_RECOVER(1'b1), .LOOP_W(10)) dut_u (
    .MCLK_I(clk), .ARST_N_I(rst_n), .CMP_I(cmp), .SUPPLY_ON_I(sup_on),
    .SUPPLY_OFF_I(sup_off), .FOLDBACK_ACTIVE_I(fold),
    .BRIGHTNESS_FULL_I(bright), .FOLDBACK_SKIP_I(skip),
    .MAJOR_FAULT_I(major), .AMP_SINKING_I(sink), .LOOP_LEVEL_I(lvl),
    .GATE_O(gate), .ON_LATCH_O(on_l), .SETPOINT_O(sp),
    .LOOP_GROUND_O(gnd), .BOOST_SRC_O(boost), .REF_FULL_O(rf),
    .HIGH_LINE_O(hl), .SHORT_FAULT_O(sf), .LATCHED_O(lat));
  // A latching copy shares the stimulus to exercise the latch-off variant.
  qvs_sequencer #(.SHORT_LIMIT(SL), .RECOVER_LIMIT(RL), .BLANK_LIMIT(BL),
    .TIMEOUT_LIMIT(TL), .AUTO_RECOVER(1'b0), .LOOP_W(10)) dut_latch_u (
    .MCLK_I(clk), .ARST_N_I(rst_n), .CMP_I(cmp), .SUPPLY_ON_I(sup_on),
    .SUPPLY_OFF_I(sup_off), .FOLDBACK_ACTIVE_I(fold),
    .BRIGHTNESS_FULL_I(bright), .FOLDBACK_SKIP_I(skip),
    .MAJOR_FAULT_I(major), .AMP_SINKING_I(sink), .LOOP_LEVEL_I(lvl),
    .GATE_O(gate2), .ON_LATCH_O(), .SETPOINT_O(),
    .LOOP_GROUND_O(gnd2), .BOOST_SRC_O(), .REF_FULL_O(),
    .HIGH_LINE_O(), .SHORT_FAULT_O(), .LATCHED_O(lat2));
  qvs_partner partner_u (.clk_i(clk), .gate_i(gate), .mode_i(mode),
    .valley_below_o(vb), .short_release_o(sr), .cs_above_o(cs));
  initial forever #2 clk = ~clk;
  // The loop level swings 360/440 every cycle to mimic filter ripple.
  always @(posedge clk) #1 lvl = lvl ^ 10'h0d0;
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_gate(input logic v, output int n);
    n = 0;
    while (gate !== v && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic off_len(output int n);
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    wait_gate(1'b1, n);
  endtask
  always @(posedge clk) begin
    #1;
    if (cs && g_q) chk("gate_end", 0, gate);
    chk("on_latch", gate, on_l);
    g_q = gate;
  end
  task automatic t_start;
    chk("off_ground", 1, gnd);
    sup_on = 1'b1;
    cyc(3);
    chk("boost", 1, boost);
    chk("ground", 0, gnd);
    sink = 1'b1;
    cyc(3);
    chk("boost_off", 0, boost);
  endtask
  task automatic t_ref;
    for (int i = 0; i < 4; i++) begin
      fold = i[1];
      bright = i[0];
      cyc(2);
      chk("ref_full", i == 1, rf);
    end
    fold = 1'b0;
    bright = 1'b1;
  endtask
  task automatic t_valley;
    int h, l, f, d;
    off_len(h);
    lo = 1'b1;
    cyc(BL - 1);
    chk("still_high", 1, hl);
    cyc(4);
    chk("low_line", 0, hl);
    off_len(l);
    chk("valley_high", 8, h - l);
    fold = 1'b1;
    skip = 3'h2;
    off_len(f);
    chk("valley_fold", 16, f - l);
    fold = 1'b0;
    lo = 1'b0;
    hi = 1'b1;
    cyc(1);
    chk("high_now", 1, hl);
    hi = 1'b0;
    mode = 2'h1;
    off_len(d);
    chk("timeout", 1, d - l >= TL - 1 && d - l <= TL + 1);
  endtask
  task automatic t_setpt;
    cyc(200);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      chk("setpoint", 1, sp >= 10'd90 && sp <= 10'd104);
    end
  endtask
  task automatic t_short;
    int k, bad;
    wait_gate(1'b1, k);
    wait_gate(1'b0, k);
    cyc(3);
    mode = 2'h2;
    k = 0;
    while (sf !== 1'b1 && k < SL + 20) begin
      cyc(1);
      k++;
    end
    chk("short_time", 1, k >= SL - 4 && k <= SL + 2);
    mode = 2'h0;
    bad = 0;
    cyc(2);
    repeat (RL - 6) begin
      cyc(1);
      if (gate !== 1'b0 || gnd !== 1'b1) bad++;
    end
    chk("recover_hold", 0, bad);
    chk("latched", 1, lat2);
    chk("latch_gate", 0, gate2);
    chk("latch_ground", 1, gnd2);
    wait_gate(1'b1, k);
    chk("recover_back", 1, k < 60);
    chk("not_latched", 0, lat);
  endtask
  task automatic t_major;
    int k;
    wait_gate(1'b1, k);
    major = 1'b1;
    cyc(2);
    chk("major_gate", 0, gate);
    chk("major_ground", 1, gnd);
    major = 1'b0;
    wait_gate(1'b1, k);
    chk("major_back", 1, k > RL - 10 && k < RL + 60);
  endtask
  task automatic t_uvlo;
    int k;
    sup_on = 1'b0;
    sup_off = 1'b1;
    cyc(2);
    chk("uv_gate", 0, gate);
    chk("uv_ground", 0, gnd);
    cyc(20);
    chk("uv_idle", 0, gate);
    sup_off = 1'b0;
    sup_on = 1'b1;
    wait_gate(1'b1, k);
    chk("uv_retry", 1, k < 40);
    chk("latch_stays", 1, lat2);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    t_start();
    t_ref();
    t_valley();
    t_setpt();
    t_short();
    t_major();
    t_uvlo();
    complete_run();
  end
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule
